//--- logic/sd_err_irq_pkg.sv
// Constants and carrier types for the SD host error interrupt signal mask.
// Assumes a 32-bit Avalon-MM register slave clocked by the peripheral bus clock.
package sd_err_irq_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int BE_W = 4;
  localparam int NUM_ERR = 10;
  localparam int LOW_W = 10;
  localparam int RES_W = 6;
  localparam int GAP_W = 5;

  // Byte addresses of the registers.
  localparam logic [3:0] OFS_SIG_EN = 4'h0;
  localparam logic [3:0] OFS_ERR_STAT = 4'h4;
  localparam logic [3:0] OFS_ERR_PEND = 4'h8;

  // Field positions inside the signal enable register.
  localparam int ERR_LSB = 16;
  localparam int ERR_MSB = 25;
  localparam int RES_LSB = 26;
  localparam int SUMMARY_BIT = 15;
  localparam int LOW_MSB = 9;

  // Reset values.
  localparam logic [NUM_ERR-1:0] ERR_EN_RESET = 10'h000;
  localparam logic [LOW_W-1:0] LOW_RESET = 10'h0ff;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // Index of each error source inside the ten-bit error field.
  localparam int IDX_CMD_TIMEOUT = 0;
  localparam int IDX_CMD_CRC = 1;
  localparam int IDX_CMD_ENDBIT = 2;
  localparam int IDX_CMD_INDEX = 3;
  localparam int IDX_DATA_TIMEOUT = 4;
  localparam int IDX_DATA_CRC = 5;
  localparam int IDX_DATA_ENDBIT = 6;
  localparam int IDX_CURRENT_LIMIT = 7;
  localparam int IDX_AUTO_STOP = 8;
  localparam int IDX_SG_DMA = 9;

  // Signal enables, in register order from bit 25 down to bit 16.
  typedef struct packed {
    logic sg_dma_err_sig_en;
    logic auto_stop_cmd_err_sig_en;
    logic current_limit_err_sig_en;
    logic data_endbit_err_sig_en;
    logic data_crc_err_sig_en;
    logic data_timeout_err_sig_en;
    logic cmd_index_err_sig_en;
    logic cmd_endbit_err_sig_en;
    logic cmd_crc_err_sig_en;
    logic cmd_timeout_err_sig_en;
  } err_sig_en_t;

  // One-cycle error events from the SD host core, same order as the enables.
  typedef struct packed {
    logic sg_dma;
    logic auto_stop_cmd;
    logic current_limit;
    logic data_endbit;
    logic data_crc;
    logic data_timeout;
    logic cmd_index;
    logic cmd_endbit;
    logic cmd_crc;
    logic cmd_timeout;
  } err_event_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [BE_W-1:0] byteenable;
    logic [DATA_W-1:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
  } avmm_rsp_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage

//--- logic/err_latch.sv
// One sticky error status bit with its signal-enable gate.
// Assumes a one-cycle set pulse and a one-cycle clear pulse on mclk.
`timescale 1ns/100ps
module err_latch (
  input wire logic mclk,
  input wire logic rst,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  input wire logic sig_en,
  output logic status_q,
  output logic pend
);

  logic status_d;

  // A new event in the clearing cycle keeps the bit set.
  always_comb begin
    status_d = status_q;
    if (clear_pulse) begin
      status_d = 1'b0;
    end
    if (set_pulse) begin
      status_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_q <= 1'b0;
    end else begin
      status_q <= status_d;
    end
  end

  // The enable gates only the request; the latched status is untouched.
  assign pend = status_d & sig_en;

endmodule // err_latch

//--- logic/sd_err_irq_mask.sv
// Upper half of the SD host interrupt signal enable register, error status latches
// and the interrupt request toward the processor interrupt controller.
// Assumes an Avalon-MM master on mclk and one-cycle error pulses from the SD core.
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps

module sd_err_irq_mask #(
  parameter int NUM_ERR = sd_err_irq_pkg::NUM_ERR,
  parameter int DATA_W = sd_err_irq_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire sd_err_irq_pkg::avmm_req_t avs_req,
  output sd_err_irq_pkg::avmm_rsp_t avs_rsp,
  input wire sd_err_irq_pkg::err_event_t err_event,
  output logic err_irq_q
);

  // Elaboration checks: the register layout must fill exactly one bus word.
  if (NUM_ERR != sd_err_irq_pkg::NUM_ERR) begin : g_bad_num_err
    $error("NUM_ERR must match the ten error sources of the register");
  end
  if (DATA_W != sd_err_irq_pkg::DATA_W) begin : g_bad_data_w
    $error("DATA_W must be 32");
  end
  if (sd_err_irq_pkg::ERR_MSB - sd_err_irq_pkg::ERR_LSB + 1 != NUM_ERR) begin : g_bad_err_field
    $error("Enable field width must equal the number of error sources");
  end
  if (sd_err_irq_pkg::RES_LSB != sd_err_irq_pkg::ERR_MSB + 1) begin : g_bad_res_field
    $error("Reserved field must sit directly above the enable field");
  end
  if (sd_err_irq_pkg::RES_W != DATA_W - sd_err_irq_pkg::RES_LSB) begin : g_bad_res_w
    $error("Reserved field must reach the top bit of the word");
  end
  if (sd_err_irq_pkg::SUMMARY_BIT != sd_err_irq_pkg::ERR_LSB - 1) begin : g_bad_summary
    $error("Summary flag must sit directly below the enable field");
  end
  if (sd_err_irq_pkg::LOW_W != sd_err_irq_pkg::LOW_MSB + 1) begin : g_bad_low_w
    $error("Low field width must match its top bit");
  end
  if (sd_err_irq_pkg::GAP_W !=
      sd_err_irq_pkg::SUMMARY_BIT - sd_err_irq_pkg::LOW_W) begin : g_bad_gap_w
    $error("Gap between low field and summary flag is inconsistent");
  end
  if ((DATA_W % sd_err_irq_pkg::BE_W) != 0) begin : g_bad_lanes
    $error("Byte enables must split the data word into equal lanes");
  end
  // Overlapping offsets would let one access hit two registers.
  if ((sd_err_irq_pkg::OFS_SIG_EN == sd_err_irq_pkg::OFS_ERR_STAT) ||
      (sd_err_irq_pkg::OFS_SIG_EN == sd_err_irq_pkg::OFS_ERR_PEND) ||
      (sd_err_irq_pkg::OFS_ERR_STAT == sd_err_irq_pkg::OFS_ERR_PEND)) begin : g_bad_offsets
    $error("Register offsets must be distinct");
  end

  // Bus handshake state.
  sd_err_irq_pkg::bus_state_t bus_state_q;
  sd_err_irq_pkg::bus_state_t bus_state_d;
  logic waitrequest_q;
  logic waitrequest_d;
  logic [DATA_W-1:0] readdata_q;
  logic [DATA_W-1:0] readdata_d;

  // Register contents.
  sd_err_irq_pkg::err_sig_en_t sig_en_q;
  sd_err_irq_pkg::err_sig_en_t sig_en_d;
  logic [sd_err_irq_pkg::LOW_W-1:0] low_q;
  logic [sd_err_irq_pkg::LOW_W-1:0] low_d;
  logic err_irq_d;

  // Decode and status wiring.
  logic req_any;
  logic commit;
  logic sel_sig_en;
  logic sel_stat;
  logic sel_pend;
  logic [DATA_W-1:0] be_mask;
  logic [DATA_W-1:0] sig_en_word;
  logic [DATA_W-1:0] sig_en_merged;
  logic [NUM_ERR-1:0] en_vec;
  logic [NUM_ERR-1:0] ev_vec;
  logic [NUM_ERR-1:0] clr_vec;
  logic [NUM_ERR-1:0] stat_vec;
  logic [NUM_ERR-1:0] pend_vec;
  logic low_summary;
  logic wr_sig_en;
  logic wr_stat;
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] pend_word;
  logic [DATA_W-1:0] rd_word;

  assign req_any = avs_req.read | avs_req.write;
  // The access takes effect at the edge where the master sees waitrequest low.
  assign commit = req_any & ~waitrequest_q;
  assign sel_sig_en = (avs_req.address == sd_err_irq_pkg::OFS_SIG_EN);
  assign sel_stat = (avs_req.address == sd_err_irq_pkg::OFS_ERR_STAT);
  assign sel_pend = (avs_req.address == sd_err_irq_pkg::OFS_ERR_PEND);

  // Register side effects happen only on the committing edge.
  assign wr_sig_en = commit & avs_req.write & sel_sig_en;
  assign wr_stat = commit & avs_req.write & sel_stat;

  // Expand byte enables into a bit mask.
  localparam int LANE_W = DATA_W / sd_err_irq_pkg::BE_W;
  genvar lane;
  generate
    for (lane = 0; lane < sd_err_irq_pkg::BE_W; lane++) begin : g_be
      assign be_mask[lane*LANE_W +: LANE_W] = {LANE_W{avs_req.byteenable[lane]}};
    end
  endgenerate

  assign low_summary = |low_q;

  // Read image of the signal enable register.
  assign sig_en_word = {
    {sd_err_irq_pkg::RES_W{1'b0}},
    sig_en_q,
    low_summary,
    {sd_err_irq_pkg::GAP_W{1'b0}},
    low_q
  };

  assign sig_en_merged = (sig_en_word & ~be_mask) | (avs_req.writedata & be_mask);

  // Route each enable onto its error source gate.
  always_comb begin
    en_vec = '0;
    en_vec[sd_err_irq_pkg::IDX_SG_DMA] = sig_en_q.sg_dma_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_AUTO_STOP] = sig_en_q.auto_stop_cmd_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_CURRENT_LIMIT] = sig_en_q.current_limit_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_DATA_ENDBIT] = sig_en_q.data_endbit_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_DATA_CRC] = sig_en_q.data_crc_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_DATA_TIMEOUT] = sig_en_q.data_timeout_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_CMD_INDEX] = sig_en_q.cmd_index_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_CMD_ENDBIT] = sig_en_q.cmd_endbit_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_CMD_CRC] = sig_en_q.cmd_crc_err_sig_en;
    en_vec[sd_err_irq_pkg::IDX_CMD_TIMEOUT] = sig_en_q.cmd_timeout_err_sig_en;
  end

  assign ev_vec = err_event;

  // Software clears status bits by writing one to them.
  assign clr_vec = wr_stat ?
    (avs_req.writedata[sd_err_irq_pkg::ERR_MSB:sd_err_irq_pkg::ERR_LSB] &
     be_mask[sd_err_irq_pkg::ERR_MSB:sd_err_irq_pkg::ERR_LSB]) : '0;

  genvar src;
  generate
    for (src = 0; src < NUM_ERR; src++) begin : g_err
      err_latch u_latch (
        .mclk(mclk),
        .rst(rst),
        .set_pulse(ev_vec[src]),
        .clear_pulse(clr_vec[src]),
        .sig_en(en_vec[src]),
        .status_q(stat_vec[src]),
        .pend(pend_vec[src])
      );
    end
  endgenerate

  // Read images of the status and pending registers; pending shows status under its enable.
  assign stat_word = {
    {sd_err_irq_pkg::RES_W{1'b0}},
    stat_vec,
    {sd_err_irq_pkg::ERR_LSB{1'b0}}
  };
  assign pend_word = {
    {sd_err_irq_pkg::RES_W{1'b0}},
    stat_vec & en_vec,
    {sd_err_irq_pkg::ERR_LSB{1'b0}}
  };

  // Writes and unmapped addresses answer with a zero word.
  always_comb begin
    rd_word = sd_err_irq_pkg::ZERO_WORD;
    if (avs_req.read & sel_sig_en) begin
      rd_word = sig_en_word;
    end
    if (avs_req.read & sel_stat) begin
      rd_word = stat_word;
    end
    if (avs_req.read & sel_pend) begin
      rd_word = pend_word;
    end
  end

  // Bus handshake: one wait cycle, then one cycle with waitrequest low.
  // Both answer signals come from flops, so the master sees a clean one-cycle window.
  always_comb begin
    bus_state_d = bus_state_q;
    waitrequest_d = 1'b1;
    readdata_d = readdata_q;
    unique case (bus_state_q)
      sd_err_irq_pkg::BUS_IDLE: begin
        if (req_any) begin
          bus_state_d = sd_err_irq_pkg::BUS_ANSWER;
          waitrequest_d = 1'b0;
          readdata_d = rd_word;
        end
      end
      sd_err_irq_pkg::BUS_ANSWER: begin
        bus_state_d = sd_err_irq_pkg::BUS_IDLE;
        waitrequest_d = 1'b1;
      end
      default: begin
        bus_state_d = sd_err_irq_pkg::BUS_IDLE;
        waitrequest_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_state_q <= sd_err_irq_pkg::BUS_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q <= sd_err_irq_pkg::ZERO_WORD;
    end else begin
      bus_state_q <= bus_state_d;
      waitrequest_q <= waitrequest_d;
      readdata_q <= readdata_d;
    end
  end

  // Register writes to the signal enable register.
  always_comb begin
    sig_en_d = sig_en_q;
    low_d = low_q;
    if (wr_sig_en) begin
      sig_en_d = sig_en_merged[sd_err_irq_pkg::ERR_MSB:sd_err_irq_pkg::ERR_LSB];
      low_d = sig_en_merged[sd_err_irq_pkg::LOW_MSB:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sig_en_q <= sd_err_irq_pkg::ERR_EN_RESET;
      low_q <= sd_err_irq_pkg::LOW_RESET;
    end else begin
      sig_en_q <= sig_en_d;
      low_q <= low_d;
    end
  end

  // Interrupt request from next-state status, gated by the current enables.
  always_comb begin
    err_irq_d = |pend_vec;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      err_irq_q <= 1'b0;
    end else begin
      err_irq_q <= err_irq_d;
    end
  end

  assign avs_rsp.waitrequest = waitrequest_q;
  assign avs_rsp.readdata = readdata_q;

endmodule // sd_err_irq_mask

//--- tb/irq_sink.sv
// Interrupt controller stand-in that counts request rises.
// Assumes a level request from a register on mclk.
`timescale 1ns/100ps
module irq_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq,
  output int rises
);
  logic irq_q;
  always @(posedge mclk) begin
    irq_q <= rst ? 1'b0 : irq;
    if (rst) begin
      rises <= 0;
    end else if (irq && !irq_q) begin
      rises <= rises + 1;
    end
  end
endmodule // irq_sink

//--- tb/sd_err_irq_mask_props.sv
// Port checker for the error signal mask block.
// Assumes one-cycle bus answers and one-cycle error pulses on mclk.
`timescale 1ns/100ps
module sd_err_irq_mask_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire sd_err_irq_pkg::avmm_req_t avs_req,
  input wire sd_err_irq_pkg::avmm_rsp_t avs_rsp,
  input wire sd_err_irq_pkg::err_event_t err_event,
  input wire logic err_irq_q
);
  logic [9:0] en_q;
  logic wr0;
  logic rd0;
  logic rd8;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  assign wr0 = avs_req.write && !avs_rsp.waitrequest && avs_req.address == 4'h0;
  assign rd0 = avs_req.read && !avs_rsp.waitrequest && avs_req.address == 4'h0;
  assign rd8 = avs_req.read && !avs_rsp.waitrequest && avs_req.address == 4'h8;
  // Mirror of the enable field, updated at the edge where a write commits.
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_q <= 10'h000;
    end else if (wr0) begin
      en_q[7:0] <= avs_req.byteenable[2] ? avs_req.writedata[23:16] : en_q[7:0];
      en_q[9:8] <= avs_req.byteenable[3] ? avs_req.writedata[25:24] : en_q[9:8];
    end
  end
  a_answer_next: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest) else $error("bus answer late");
  a_wait_one: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("waitrequest low too long");
  a_answer_cause: assert property (!avs_rsp.waitrequest
    |-> $past(avs_req.read) || $past(avs_req.write)) else $error("answer without request");
  a_reset_quiet: assert property ($fell(rst) |-> avs_rsp.waitrequest && !err_irq_q)
    else $error("outputs busy after reset");
  a_reserved_zero: assert property (rd0 |-> avs_rsp.readdata[31:26] == 6'h00)
    else $error("reserved bits not zero");
  a_summary_flag: assert property (rd0 |-> avs_rsp.readdata[15] == |avs_rsp.readdata[9:0])
    else $error("summary flag wrong");
  a_pend_clean: assert property (rd8 |-> avs_rsp.readdata[15:0] == 16'h0000)
    else $error("pending has stray bits");
  a_irq_unmask: assert property (|(err_event & en_q) |=> err_irq_q)
    else $error("enabled error gave no request");
  // An enable write commits two edges before the request it unmasks is seen high.
  a_irq_cause: assert property ($rose(err_irq_q)
    |-> $past(err_event) != 10'h000 || $past(wr0, 2))
    else $error("request rose without cause");
endmodule // sd_err_irq_mask_chk
bind sd_err_irq_mask sd_err_irq_mask_chk chk_u (.mclk(mclk), .rst(rst), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .err_event(err_event), .err_irq_q(err_irq_q));

//--- tb/tb_top.sv
// Self-checking bench for the error signal mask block.
// Assumes the one-cycle Avalon answer of the block.
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  sd_err_irq_pkg::avmm_req_t req = '0;
  sd_err_irq_pkg::avmm_rsp_t rsp;
  sd_err_irq_pkg::err_event_t ev = '0;
  logic irq;
  int rises;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [31:0] irq_w;
  assign irq_w = {31'h0, irq};
  always #5 mclk = ~mclk;
  sd_err_irq_mask dut_u (.mclk(mclk), .rst(rst), .avs_req(req), .avs_rsp(rsp),
    .err_event(ev), .err_irq_q(irq));
  irq_sink sink_u (.mclk(mclk), .rst(rst), .irq(irq), .rises(rises));
  task automatic end_sim();
    $display("errors %0d in %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.byteenable <= 4'hf;
    req.writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (rsp.waitrequest === 1'b0) break;
    end
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n == 20) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic pulse(input logic [9:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= '0;
    @(negedge mclk);
  endtask
  task automatic reset_values();
    bus(0, 4'h0, 0);
    chk("enable", 32'h0000_80ff, rd);
    bus(0, 4'h4, 0);
    chk("status", 32'h0, rd);
    bus(0, 4'hc, 0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic field_access();
    bus(1, 4'h0, 32'hffff_ffff);
    bus(0, 4'h0, 0);
    chk("enable", 32'h03ff_83ff, rd);
    bus(1, 4'h0, 32'h0000_0200);
    bus(0, 4'h0, 0);
    chk("enable", 32'h0000_8200, rd);
    bus(1, 4'h0, 32'h0);
    bus(0, 4'h0, 0);
    chk("enable", 32'h0, rd);
  endtask
  // Each source alone is enabled while its neighbour fires masked beside it.
  task automatic source_gate();
    logic [9:0] m;
    logic [9:0] nb;
    for (int i = 0; i < 10; i++) begin
      nb = 10'h001 << ((i + 1) % 10);
      m = (10'h001 << i) | nb;
      bus(1, 4'h0, 32'h1 << (16 + i));
      pulse(nb);
      chk("irq", 32'h0, irq_w);
      pulse(m);
      chk("irq", 32'h1, irq_w);
      bus(0, 4'h4, 0);
      chk("status", {6'h0, m, 16'h0}, rd);
      bus(0, 4'h8, 0);
      chk("pending", 32'h1 << (16 + i), rd);
      bus(1, 4'h4, {6'h0, m, 16'h0});
      @(negedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
    end
    chk("rises", 32'd10, rises);
  endtask
  task automatic masking();
    bus(1, 4'h0, 32'h0);
    pulse(10'h008);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1, 4'h0, 32'h0008_0000);
    @(posedge mclk);
    @(negedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1, 4'h4, 32'h0008_0000);
    @(negedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    reset_values();
    field_access();
    source_gate();
    masking();
    end_sim();
  end
endmodule // tb_top
